// ==== src/vmeam_cfg.sv ====
// Notes on behaviour
// - An empty group in a nonzero slave accept register means the slave accepts no modifier.
// - Slave accept all zero: decode off, accept all codes, function code pins floated.
// - Bits 0-2 cycle type, bits 3-5 address space, bits 6-7 privilege.
// - Accept every code built from one set bit of each group, except program or block cycles in the short space.
// - With source select set, master drives the six stored code bits.
// - Stored master code is driven unchecked, exactly as stored.
// - With source select clear, master derives the code per cycle.
// - Selected with function code all ones: stored code driven regardless of select.
// - VME level n is honoured only when mask bit n is set.
// - Unmasked VME request asks the processor for an acknowledge cycle.
// - Utility mask bits 1-7 unmask the seven utility sources.
// - Utility sources sit at fixed levels 1 to 7.
// - Acknowledge-done interrupt raised after a VME acknowledge cycle, when unmasked.
// - Monitor 0 and 1 hits interrupt, each under its own unmask bit.
// - Low system-failure line interrupts while unmasked.
// - Posted write bus error interrupts at level 7 when unmasked.
// - Vector bits 0-2 follow local address lines 1-3, the source id.
// - Vector bits 3-7 are writable base, cleared by any reset.
`timescale 1ns/1ps
`default_nettype none
`include "vmeam_regs.svh"

module vmeam_cfg
  import vmeam_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Local register port
  input wire logic cs_n_i,
  input wire logic ds_n_i,
  input wire logic read_i,
  input wire logic piack_n_i,
  input wire logic [7:0] pa_i,
  input wire logic [7:0] pd_i,
  output logic [7:0] pd_o,
  output logic pd_oe_n_o,
  output logic ack_n_o,
  // Slave modifier decode
  input wire logic [5:0] vme_am_i,
  output logic slave_am_match_o,
  output logic [2:0] cpu_function_code_o,
  output logic cpu_function_code_oe_n_o,
  // Master modifier sourcing
  input wire logic mst_sel_i,
  input wire logic [2:0] cpu_fc_i,
  input wire logic [1:0] mst_size_i,
  output logic [5:0] vme_am_o,
  output logic vme_am_oe_n_o,
  // VMEbus interrupt handler
  input wire logic [7:1] vme_irq_n_i,
  output logic vme_irq_req_o,
  output logic [2:0] vme_irq_level_o,
  // Utility interrupt sources
  input wire logic attn_low_flag_i,
  input wire logic attn_high_flag_i,
  input wire logic mon0_hit_i,
  input wire logic mon1_hit_i,
  input wire logic vme_iack_done_i,
  input wire logic sysfail_n_i,
  input wire logic posted_write_bus_error_i,
  output logic [2:0] util_irq_level_o,
  output logic [7:1] util_pending_o
);

  // Registers
  logic [7:0] slave_modifier_accept_ff;
  logic [7:0] master_modifier_code_ff;
  logic [7:1] vme_irq_level_mask_ff;
  logic [7:1] utility_irq_mask_ff;
  logic [4:0] vector_base_bits_ff;
  logic [7:1] src_latch_ff;

  // Bus cycle state
  vmeam_bus_state_t state_ff;
  vmeam_bus_state_t nxt_state;
  logic [7:0] pd_ff;
  logic pd_oe_n_ff;
  logic ack_n_ff;

  // Registered outputs
  logic slave_am_match_ff;
  logic [2:0] fc_ff;
  logic fc_oe_n_ff;
  logic [5:0] vme_am_ff;
  logic vme_am_oe_n_ff;
  logic vme_irq_req_ff;
  logic [2:0] vme_irq_level_ff;
  logic [2:0] util_level_ff;
  logic [7:1] util_pending_ff;

  // Bus decode
  wire cycle_start = ~ds_n_i && (state_ff == VMEAM_BUS_IDLE);
  wire reg_take = cycle_start && ~cs_n_i && piack_n_i;
  wire iack_take = cycle_start && ~piack_n_i;
  wire wr_take = reg_take && ~read_i;
  wire wr_slv = wr_take && (pa_i == `VMEAM_OFS_SLV_ACCEPT);
  wire wr_mst = wr_take && (pa_i == `VMEAM_OFS_MST_CODE);
  wire wr_vmask = wr_take && (pa_i == `VMEAM_OFS_VME_MASK);
  wire wr_umask = wr_take && (pa_i == `VMEAM_OFS_UTIL_MASK);
  wire wr_vec = wr_take && (pa_i == `VMEAM_OFS_UTIL_VEC);
  wire [2:0] ack_id = pa_i[3:1];

  // Vector low bits mirror address lines 1-3, also on plain reads
  wire [7:0] vector_rd = {vector_base_bits_ff, pa_i[3:1]};

  logic [7:0] rd_data;
  always_comb begin
    case (pa_i)
      `VMEAM_OFS_SLV_ACCEPT: rd_data = slave_modifier_accept_ff;
      `VMEAM_OFS_MST_CODE: rd_data = master_modifier_code_ff;
      `VMEAM_OFS_VME_MASK: rd_data = {vme_irq_level_mask_ff, 1'b0};
      `VMEAM_OFS_UTIL_MASK: rd_data = {utility_irq_mask_ff, 1'b0};
      `VMEAM_OFS_UTIL_VEC: rd_data = vector_rd;
      default: rd_data = `VMEAM_RST_BYTE;
    endcase
  end

  // Handshake: acknowledge one cycle after the strobe, hold until released
  always_comb begin
    case (state_ff)
      VMEAM_BUS_IDLE: nxt_state = (reg_take || iack_take) ? VMEAM_BUS_ACK : VMEAM_BUS_IDLE;
      VMEAM_BUS_ACK: nxt_state = ds_n_i ? VMEAM_BUS_IDLE : VMEAM_BUS_ACK;
      default: nxt_state = VMEAM_BUS_IDLE;
    endcase
  end

  wire [7:0] nxt_pd = iack_take ? vector_rd : rd_data;
  wire nxt_drive = (reg_take && read_i) || iack_take;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= VMEAM_BUS_IDLE;
      pd_ff <= `VMEAM_RST_BYTE;
      pd_oe_n_ff <= 1'b1;
      ack_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      if (nxt_drive) begin
        pd_ff <= nxt_pd;
      end
      if (nxt_drive) begin
        pd_oe_n_ff <= 1'b0;
      end else if (nxt_state == VMEAM_BUS_IDLE) begin
        pd_oe_n_ff <= 1'b1;
      end
      ack_n_ff <= (nxt_state != VMEAM_BUS_ACK);
    end
  end

  // Register writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slave_modifier_accept_ff <= `VMEAM_RST_BYTE;
      master_modifier_code_ff <= `VMEAM_RST_BYTE;
      vme_irq_level_mask_ff <= 7'h00;
      utility_irq_mask_ff <= 7'h00;
      vector_base_bits_ff <= `VMEAM_RST_BASE;
    end else begin
      if (wr_slv) begin
        slave_modifier_accept_ff <= pd_i;
      end
      if (wr_mst) begin
        master_modifier_code_ff <= {pd_i[7], 1'b0, pd_i[5:0]};
      end
      if (wr_vmask) begin
        vme_irq_level_mask_ff <= pd_i[7:1];
      end
      if (wr_umask) begin
        utility_irq_mask_ff <= pd_i[7:1];
      end
      if (wr_vec) begin
        vector_base_bits_ff <= pd_i[7:3];
      end
    end
  end

  // Slave modifier acceptance
  logic am_match;
  logic decode_off;

  vmeam_am_decode u_am_decode (
    .accept_i(slave_modifier_accept_ff),
    .am_i(vme_am_i),
    .match_o(am_match),
    .decode_off_o(decode_off)
  );

  // Function code from any incoming modifier, accepted or not: supervisor flag, program or data
  wire [2:0] fc_from_am = {vme_am_i[2], vme_am_i[1:0] == `VMEAM_TYPE_PROG, vme_am_i[1:0] != `VMEAM_TYPE_PROG};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slave_am_match_ff <= 1'b0;
      fc_ff <= 3'h0;
      fc_oe_n_ff <= 1'b1;
    end else begin
      slave_am_match_ff <= am_match;
      fc_ff <= fc_from_am;
      fc_oe_n_ff <= decode_off;
    end
  end

  // Master modifier sourcing
  logic [2:0] auto_space;
  always_comb begin
    case (vmeam_size_t'(mst_size_i))
      VMEAM_SIZE_A16: auto_space = `VMEAM_SPACE_A16;
      VMEAM_SIZE_A24: auto_space = `VMEAM_SPACE_A24;
      VMEAM_SIZE_A32: auto_space = `VMEAM_SPACE_A32;
      default: auto_space = `VMEAM_SPACE_A32;
    endcase
  end

  wire auto_prog = cpu_fc_i[1] && (auto_space != `VMEAM_SPACE_A16);
  wire [1:0] auto_type = auto_prog ? `VMEAM_TYPE_PROG : `VMEAM_TYPE_DATA;
  wire [5:0] auto_code = {auto_space, cpu_fc_i[2], auto_type};
  wire fc_force = mst_sel_i && (cpu_fc_i == `VMEAM_FC_ALL_ONES);
  wire use_stored = master_modifier_code_ff[`VMEAM_MST_SEL_BIT] || fc_force;
  // Stored code goes out unchecked
  wire [5:0] nxt_am = use_stored ? master_modifier_code_ff[`VMEAM_MST_CODE_W-1:0] : auto_code;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vme_am_ff <= 6'h00;
      vme_am_oe_n_ff <= 1'b1;
    end else begin
      vme_am_ff <= nxt_am;
      vme_am_oe_n_ff <= ~mst_sel_i;
    end
  end

  // VMEbus interrupt handler
  wire [7:1] vme_pend = ~vme_irq_n_i & vme_irq_level_mask_ff;
  logic [2:0] vme_level;

  vmeam_util_prio u_vme_prio (
    .pend_i(vme_pend),
    .level_o(vme_level)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vme_irq_req_ff <= 1'b0;
      vme_irq_level_ff <= 3'h0;
    end else begin
      vme_irq_req_ff <= |vme_pend;
      vme_irq_level_ff <= vme_level;
    end
  end

  // Utility sources indexed by id
  logic [7:1] src_event;
  assign src_event[`VMEAM_ID_ATTN_LOW] = attn_low_flag_i;
  assign src_event[`VMEAM_ID_MON0] = mon0_hit_i;
  assign src_event[`VMEAM_ID_ACK_DONE] = vme_iack_done_i;
  assign src_event[`VMEAM_ID_MON1] = mon1_hit_i;
  assign src_event[`VMEAM_ID_ATTN_HIGH] = attn_high_flag_i;
  assign src_event[`VMEAM_ID_SYSFAIL] = ~sysfail_n_i;
  assign src_event[`VMEAM_ID_POSTED_ERR] = posted_write_bus_error_i;

  localparam logic [7:0] STICKY = `VMEAM_STICKY_SRC;
  logic [7:1] nxt_src_latch;

  // Pulsed sources held until acknowledged; a new event beats the clear
  for (genvar g = 1; g < 8; g++) begin : g_src
    wire clr = iack_take && (ack_id == 3'(g));
    if (STICKY[g]) begin : g_sticky
      assign nxt_src_latch[g] = src_event[g] || (src_latch_ff[g] && !clr);
    end else begin : g_level
      assign nxt_src_latch[g] = src_event[g];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      src_latch_ff <= 7'h00;
    end else begin
      src_latch_ff <= nxt_src_latch;
    end
  end

  wire [7:1] util_pend = src_latch_ff & utility_irq_mask_ff;
  logic [2:0] util_level;

  vmeam_util_prio u_util_prio (
    .pend_i(util_pend),
    .level_o(util_level)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      util_level_ff <= 3'h0;
      util_pending_ff <= 7'h00;
    end else begin
      util_level_ff <= util_level;
      util_pending_ff <= util_pend;
    end
  end

  assign pd_o = pd_ff;
  assign pd_oe_n_o = pd_oe_n_ff;
  assign ack_n_o = ack_n_ff;
  assign slave_am_match_o = slave_am_match_ff;
  assign cpu_function_code_o = fc_ff;
  assign cpu_function_code_oe_n_o = fc_oe_n_ff;
  assign vme_am_o = vme_am_ff;
  assign vme_am_oe_n_o = vme_am_oe_n_ff;
  assign vme_irq_req_o = vme_irq_req_ff;
  assign vme_irq_level_o = vme_irq_level_ff;
  assign util_irq_level_o = util_level_ff;
  assign util_pending_o = util_pending_ff;

endmodule // vmeam_cfg

`default_nettype wire

// ==== src/vmeam_regs.svh ====
`ifndef VMEAM_REGS_SVH
`define VMEAM_REGS_SVH

// Local register offsets
`define VMEAM_OFS_SLV_ACCEPT 8'h0B
`define VMEAM_OFS_MST_CODE 8'h0D
`define VMEAM_OFS_VME_MASK 8'h0F
`define VMEAM_OFS_UTIL_MASK 8'h11
`define VMEAM_OFS_UTIL_VEC 8'h13

// Reset values
`define VMEAM_RST_BYTE 8'h00
`define VMEAM_RST_BASE 5'h00

// Slave accept field positions
`define VMEAM_ACC_DATA 0
`define VMEAM_ACC_PROG 1
`define VMEAM_ACC_BLOCK 2
`define VMEAM_ACC_SHORT 3
`define VMEAM_ACC_A24 4
`define VMEAM_ACC_A32 5
`define VMEAM_ACC_USER 6
`define VMEAM_ACC_PRIV 7

// Master code fields
`define VMEAM_MST_SEL_BIT 7
`define VMEAM_MST_CODE_W 6

// Modifier code pieces
`define VMEAM_SPACE_A16 3'h5
`define VMEAM_SPACE_A24 3'h7
`define VMEAM_SPACE_A32 3'h1
`define VMEAM_TYPE_DATA 2'h1
`define VMEAM_TYPE_PROG 2'h2
`define VMEAM_TYPE_BLOCK 2'h3
`define VMEAM_FC_ALL_ONES 3'h7

// Utility source ids, equal to their levels
`define VMEAM_ID_ATTN_LOW 3'h1
`define VMEAM_ID_MON0 3'h2
`define VMEAM_ID_ACK_DONE 3'h3
`define VMEAM_ID_MON1 3'h4
`define VMEAM_ID_ATTN_HIGH 3'h5
`define VMEAM_ID_SYSFAIL 3'h6
`define VMEAM_ID_POSTED_ERR 3'h7
// Sources latched until acknowledged (bit index = id)
`define VMEAM_STICKY_SRC 8'h9C

`endif

// ==== src/vmeam_pkg.sv ====
`default_nettype none

package vmeam_pkg;

  typedef enum logic [1:0] {
    VMEAM_BUS_IDLE,
    VMEAM_BUS_ACK
  } vmeam_bus_state_t;

  typedef enum logic [1:0] {
    VMEAM_SIZE_A16,
    VMEAM_SIZE_A24,
    VMEAM_SIZE_A32,
    VMEAM_SIZE_RSVD
  } vmeam_size_t;

endpackage

`default_nettype wire

// ==== src/vmeam_am_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "vmeam_regs.svh"

module vmeam_am_decode
  import vmeam_pkg::*;
(
  input wire logic [7:0] accept_i,
  input wire logic [5:0] am_i,
  output logic match_o,
  output logic decode_off_o
);

  logic grp_type_any;
  logic grp_space_any;
  logic grp_priv_any;
  logic type_ok;
  logic space_ok;
  logic priv_ok;
  logic [2:0] space;
  logic [1:0] cyc;

  assign space = am_i[5:3];
  assign cyc = am_i[1:0];
  assign decode_off_o = (accept_i == `VMEAM_RST_BYTE);
  assign grp_type_any = |accept_i[`VMEAM_ACC_BLOCK:`VMEAM_ACC_DATA];
  assign grp_space_any = |accept_i[`VMEAM_ACC_A32:`VMEAM_ACC_SHORT];
  assign grp_priv_any = |accept_i[`VMEAM_ACC_PRIV:`VMEAM_ACC_USER];
  assign type_ok = (cyc == `VMEAM_TYPE_DATA && accept_i[`VMEAM_ACC_DATA])
    || (cyc == `VMEAM_TYPE_PROG && accept_i[`VMEAM_ACC_PROG] && space != `VMEAM_SPACE_A16)
    || (cyc == `VMEAM_TYPE_BLOCK && accept_i[`VMEAM_ACC_BLOCK] && space != `VMEAM_SPACE_A16);
  assign space_ok = (space == `VMEAM_SPACE_A16 && accept_i[`VMEAM_ACC_SHORT])
    || (space == `VMEAM_SPACE_A24 && accept_i[`VMEAM_ACC_A24])
    || (space == `VMEAM_SPACE_A32 && accept_i[`VMEAM_ACC_A32]);
  assign priv_ok = am_i[2] ? accept_i[`VMEAM_ACC_PRIV] : accept_i[`VMEAM_ACC_USER];
  // Every combination of one bit per group is accepted, except program or block in the short space
  assign match_o = decode_off_o
    || (grp_type_any && grp_space_any && grp_priv_any && type_ok && space_ok && priv_ok);

endmodule // vmeam_am_decode

`default_nettype wire

// ==== src/vmeam_util_prio.sv ====
`timescale 1ns/1ps
`default_nettype none

module vmeam_util_prio
  import vmeam_pkg::*;
(
  input wire logic [7:1] pend_i,
  output logic [2:0] level_o
);

  logic [2:0] lvl_at [8];

  assign lvl_at[0] = 3'h0;
  // Highest pending level wins
  for (genvar g = 1; g < 8; g++) begin : g_prio
    assign lvl_at[g] = pend_i[g] ? 3'(g) : lvl_at[g - 1];
  end
  assign level_o = lvl_at[7];

endmodule // vmeam_util_prio

`default_nettype wire

// ==== verif/vmeam_cfg_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

module vmeam_cfg_checker
  import vmeam_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic ds_n_i,
  input wire logic read_i,
  input wire logic piack_n_i,
  input wire logic [7:0] pa_i,
  input wire logic [7:0] pd_i,
  input wire logic [7:0] pd_o,
  input wire logic pd_oe_n_o,
  input wire logic ack_n_o,
  input wire logic mst_sel_i,
  input wire logic [2:0] cpu_fc_i,
  input wire logic [5:0] vme_am_o,
  input wire logic [7:1] vme_irq_n_i,
  input wire logic vme_irq_req_o,
  input wire logic sysfail_n_i,
  input wire logic posted_write_bus_error_i,
  input wire logic [2:0] util_irq_level_o,
  input wire logic [7:1] util_pending_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [7:0] mst_ff, vm_ff, um_ff;
  wire logic wr_now = !ds_n_i && !cs_n_i && piack_n_i && !read_i && ack_n_o;

  // Shadow copies, written on the edge that takes the cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mst_ff <= 8'h00;
      vm_ff <= 8'h00;
      um_ff <= 8'h00;
    end else if (wr_now) begin
      if (pa_i == 8'h0D) mst_ff <= pd_i;
      if (pa_i == 8'h0F) vm_ff <= pd_i;
      if (pa_i == 8'h11) um_ff <= pd_i;
    end
  end

  function automatic logic [2:0] top_lvl(input logic [7:1] v);
    top_lvl = 3'h0;
    for (int i = 1; i <= 7; i++) begin
      if (v[i]) top_lvl = 3'(i);
    end
  endfunction

  sequence take_s;
    !ds_n_i && ack_n_o && $past(ds_n_i) && (!cs_n_i || !piack_n_i);
  endsequence
  sequence iack_s;
    take_s ##0 !piack_n_i;
  endsequence
  sequence fail_s;
    (!sysfail_n_i && um_ff[6])[*2];
  endsequence

  chk_ack_take: assert property (take_s |=> !ack_n_o)
    else $error("cycle not acknowledged");
  chk_ack_release: assert property (!ack_n_o && ds_n_i |=> ack_n_o && pd_oe_n_o)
    else $error("acknowledge or data drive stuck");
  chk_read_drive: assert property (take_s ##0 (read_i || !piack_n_i) |=> !pd_oe_n_o)
    else $error("read data not driven");
  chk_iack_id: assert property (iack_s |=> pd_o[2:0] == $past(pa_i[3:1]))
    else $error("vector id wrong");
  chk_fixed_code: assert property (mst_sel_i && (cpu_fc_i == 3'h7 || mst_ff[7]) |=> vme_am_o == $past(mst_ff[5:0]))
    else $error("stored modifier not driven");
  chk_vme_mask: assert property (vme_irq_req_o == |(~$past(vme_irq_n_i) & $past(vm_ff[7:1])))
    else $error("vme request mask wrong");
  chk_util_prio: assert property (util_irq_level_o == top_lvl(util_pending_o))
    else $error("utility level not highest");
  chk_util_mask: assert property ((util_pending_o & ~$past(um_ff[7:1])) == 7'h00)
    else $error("masked source pending");
  chk_sysfail_irq: assert property (fail_s |=> util_pending_o[6])
    else $error("system failure not pending");
  chk_posted_err: assert property (posted_write_bus_error_i && um_ff[7] |-> ##2 util_irq_level_o == 3'h7)
    else $error("posted error not at level 7");
endmodule // vmeam_cfg_checker

`default_nettype wire

// ==== verif/vmeam_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module vmeam_cpu_model (
  input wire logic clk_i,
  input wire logic ack_n_i,
  input wire logic [7:0] data_i,
  output logic cs_n_o,
  output logic ds_n_o,
  output logic read_o,
  output logic piack_n_o,
  output logic [7:0] addr_o,
  output logic [7:0] data_o
);
  initial begin
    cs_n_o = 1'b1;
    ds_n_o = 1'b1;
    read_o = 1'b1;
    piack_n_o = 1'b1;
    addr_o = 8'h00;
    data_o = 8'h00;
  end

  // Released address and data lines show inverted values; read_o keeps its last one
  task automatic cyc(input logic ia, input logic rd, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cs_n_o <= ia;
    piack_n_o <= !ia;
    read_o <= rd;
    addr_o <= a;
    data_o <= d;
    ds_n_o <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_n_i !== 1'b0 && n < 16);
    q = data_i;
    cs_n_o <= 1'b1;
    piack_n_o <= 1'b1;
    ds_n_o <= 1'b1;
    addr_o <= ~a;
    data_o <= ~d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_n_i !== 1'b1 && n < 32);
  endtask
endmodule // vmeam_cpu_model

`default_nettype wire

// ==== verif/vme_am_and_utility_irq_config_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module vme_am_and_utility_irq_config_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n_i, ds_n_i, read_i, piack_n_i, pd_oe_n_o, ack_n_o, vme_am_oe_n_o, vme_irq_req_o;
  logic slave_am_match_o, cpu_function_code_oe_n_o, mst_sel_i;
  logic [7:0] pa_i, pd_i, pd_o, q;
  logic [5:0] vme_am_i, vme_am_o;
  logic [2:0] cpu_function_code_o, cpu_fc_i, vme_irq_level_o, util_irq_level_o;
  logic [1:0] mst_size_i;
  logic [7:1] vme_irq_n_i, util_pending_o, src;
  int err_total = 0;
  int compares = 0;
  localparam logic [7:0] sticky_c = 8'h9C;
  logic [7:0] ofs [5] = '{8'h0B, 8'h0D, 8'h0F, 8'h11, 8'h13};
  logic [7:0] wv [5] = '{8'hFB, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] rv [5] = '{8'hFB, 8'hBF, 8'hFE, 8'hFE, 8'hF9};
  logic [7:0] acc [4] = '{8'h91, 8'hE3, 8'h90, 8'h00};
  logic [7:0] amm [4] = '{8'h2D, 8'h3E, 8'h0E, 8'h0E};
  logic [63:0] amx [4] = '{64'h2000_0000_0000_0000, 64'h6600, 64'h0, '1};
  logic [7:1] irqv [4] = '{7'h7B, 7'h77, 7'h6B, 7'h3F};
  logic [7:0] irqe [4] = '{8'h83, 8'h00, 8'h85, 8'h00};

  vmeam_cfg dut_u (
    .clk_i, .rst_i, .cs_n_i, .ds_n_i, .read_i, .piack_n_i, .pa_i, .pd_i, .pd_o, .pd_oe_n_o, .ack_n_o,
    .vme_am_i, .slave_am_match_o, .cpu_function_code_o, .cpu_function_code_oe_n_o, .mst_sel_i,
    .cpu_fc_i, .mst_size_i, .vme_am_o, .vme_am_oe_n_o, .vme_irq_n_i, .vme_irq_req_o, .vme_irq_level_o,
    .attn_low_flag_i(src[1]), .mon0_hit_i(src[2]), .vme_iack_done_i(src[3]), .mon1_hit_i(src[4]),
    .attn_high_flag_i(src[5]), .sysfail_n_i(!src[6]), .posted_write_bus_error_i(src[7]),
    .util_irq_level_o, .util_pending_o
  );

  vmeam_cpu_model cpu_u (
    .clk_i, .ack_n_i(ack_n_o), .data_i(pd_o), .cs_n_o(cs_n_i), .ds_n_o(ds_n_i), .read_o(read_i),
    .piack_n_o(piack_n_i), .addr_o(pa_i), .data_o(pd_i)
  );

  always #50 clk_i = ~clk_i;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu_u.cyc(1'b0, 1'b0, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cpu_u.cyc(1'b0, 1'b1, a, 8'h00, q);
    chk(q, exp);
  endtask

  // Level sources stay up, latched ones get a single-cycle pulse
  task automatic pulse(input int i);
    src <= 7'h01 << (i - 1);
    tick(1);
    if (sticky_c[i]) src <= 7'h00;
    tick(3);
  endtask

  initial begin
    {mst_sel_i, cpu_fc_i, mst_size_i, vme_am_i} = '0;
    vme_irq_n_i = 7'h7F;
    src = 7'h00;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      rd(ofs[k], k == 4 ? 8'h01 : 8'h00);
      wr(ofs[k], wv[k]);
      rd(ofs[k], rv[k]);
    end
    rd(8'h15, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(8'h0B, acc[k]);
      for (int c = 0; c < 64; c++) begin
        vme_am_i <= 6'(c);
        tick(2);
        chk({7'h00, slave_am_match_o}, {7'h00, amx[k][c]});
      end
      chk({4'h0, cpu_function_code_oe_n_o, cpu_function_code_o}, {4'h0, k == 3, 3'h5});
    end
    mst_sel_i <= 1'b1;
    mst_size_i <= 2'h1;
    cpu_fc_i <= 3'h6;
    wr(8'h0D, 8'h81);
    tick(2);
    chk({vme_am_oe_n_o, 1'b0, vme_am_o}, 8'h01);
    wr(8'h0D, 8'h15);
    for (int s = 0; s < 4; s++) begin
      mst_size_i <= 2'(s);
      tick(2);
      chk({2'h0, vme_am_o}, amm[s]);
    end
    cpu_fc_i <= 3'h7;
    tick(2);
    chk({2'h0, vme_am_o}, 8'h15);
    wr(8'h0F, 8'h28);
    for (int k = 0; k < 4; k++) begin
      vme_irq_n_i <= irqv[k];
      tick(2);
      chk({vme_irq_req_o, 4'h0, vme_irq_level_o}, irqe[k]);
    end
    vme_irq_n_i <= 7'h7F;
    wr(8'h13, 8'hA8);
    for (int i = 1; i < 8; i++) begin
      wr(8'h11, ~(8'h01 << i));
      pulse(i);
      chk({5'h00, util_irq_level_o}, 8'h00);
      wr(8'h11, 8'h01 << i);
      pulse(i);
      chk({5'h00, util_irq_level_o}, 8'(i));
      src <= 7'h00;
      cpu_u.cyc(1'b1, 1'b1, {4'h0, 3'(i), 1'b0}, 8'h00, q);
      chk(q, 8'hA8 | 8'(i));
      tick(3);
      chk({1'b0, util_pending_o}, 8'h00);
    end
    wr(8'h11, 8'hFE);
    src <= 7'h21;
    tick(3);
    chk({5'h00, util_irq_level_o}, 8'h06);
    src <= 7'h00;
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    rd(8'h13, 8'h01);
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    give_verdict();
  end
endmodule // vme_am_and_utility_irq_config_bench

bind vmeam_cfg vmeam_cfg_checker chk_u (
  .clk_i, .rst_i, .cs_n_i, .ds_n_i, .read_i, .piack_n_i, .pa_i, .pd_i, .pd_o, .pd_oe_n_o, .ack_n_o, .mst_sel_i,
  .cpu_fc_i, .vme_am_o, .vme_irq_n_i, .vme_irq_req_o, .sysfail_n_i, .posted_write_bus_error_i,
  .util_irq_level_o, .util_pending_o
);

`default_nettype wire
